// ---- shared/uart_status_pkg.sv ----
package uart_status_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam logic [3:0] ADDR_STATUS_A = 4'h0;
	localparam logic [3:0] ADDR_RXDATA_A = 4'h2;
	localparam logic [3:0] ADDR_TXHOLD_A = 4'h4;
	localparam logic [3:0] ADDR_CMD_A = 4'h6;
	localparam logic [3:0] ADDR_MODE_A = 4'h8;
	localparam logic [3:0] ADDR_OUT_SEL = 4'hA;
	localparam logic [3:0] ADDR_LATCH_SET = 4'hB;
	localparam logic [3:0] ADDR_LATCH_CLR = 4'hC;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'hD;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned ST_BRK = 7;
	localparam int unsigned ST_FE = 6;
	localparam int unsigned ST_PE = 5;
	localparam int unsigned ST_OVR = 4;
	localparam int unsigned ST_TX_UNDERRUN_FLAG = 3;
	localparam int unsigned ST_TX_HOLDING_EMPTY = 2;
	localparam int unsigned ST_RX_QUEUE_FULL_FLAG = 1;
	localparam int unsigned ST_RX_CHAR_AVAILABLE = 0;
	localparam int unsigned MODE_LEN_LSB = 0;
	localparam int unsigned MODE_PAR_TYPE = 2;
	localparam int unsigned MODE_PMODE_LSB = 3;
	localparam int unsigned MODE_RXIRQ_SEL = 6;
	localparam int unsigned CMD_RX_LSB = 0;
	localparam int unsigned CMD_TX_LSB = 2;
	localparam int unsigned CMD_MISC_LSB = 4;
	localparam int unsigned IRQ_BRK_B = 6;
	localparam int unsigned IRQ_RX_B = 5;
	localparam int unsigned IRQ_TX_B = 4;
	localparam int unsigned IRQ_CTR = 3;
	localparam int unsigned IRQ_BRK_A = 2;
	localparam int unsigned IRQ_RX_A = 1;
	localparam int unsigned IRQ_TX_A = 0;
	localparam int unsigned SEL_OP3_LSB = 2;
	localparam int unsigned SEL_OP2_LSB = 0;

	// ----------------------------------------------------------------
	// Encodings, reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic [1:0] PM_WITH = 2'b00;
	localparam logic [1:0] PM_FORCE = 2'b01;
	localparam logic [1:0] PM_NONE = 2'b10;
	localparam logic [1:0] PM_MULTI = 2'b11;
	localparam logic [1:0] CMD_EN = 2'b01;
	localparam logic [1:0] CMD_DIS = 2'b10;
	localparam logic [2:0] MISC_RST_RX = 3'b010;
	localparam logic [2:0] MISC_RST_TX = 3'b011;
	localparam logic [2:0] MISC_RST_ERR = 3'b100;
	localparam logic [2:0] MISC_RST_BRK = 3'b101;
	localparam logic [1:0] SEL_LATCH = 2'b00;
	localparam logic [1:0] SEL_FUNC = 2'b01;
	localparam logic [1:0] SEL_TX1X = 2'b10;
	localparam logic [1:0] SEL_RX1X = 2'b11;
	localparam logic [7:0] MODE_RESET = 8'h13;
	localparam logic [7:0] OUT_SEL_RESET = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [1:0] FIFO_DEPTH = 2'd3;
	localparam logic [3:0] SAMPLE_START = 4'h7;
	localparam logic [3:0] SAMPLE_MID = 4'hF;
	localparam logic [1:0] MARK_EDGES = 2'd2;
	localparam logic [3:0] MIN_CHAR_LEN = 4'h5;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

	typedef struct packed {
		logic brk;
		logic fe;
		logic pe;
		logic [7:0] data;
	} entry_t;

	typedef struct packed {
		logic [2:0] rx_sync;
		logic rx_line;
		rx_state_t rx_state;
		logic [3:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_shift;
		logic rx_pbit;
		entry_t [2:0] fifo;
		logic [1:0] fifo_cnt;
		entry_t hold;
		logic hold_valid;
		logic brk_active;
		logic [1:0] mark_cnt;
		logic rx_en;
		logic tx_en;
		logic overrun;
		logic rx_queue_full_flag;
		logic tx_holding_empty;
		logic tx_underrun_flag;
		logic chg_brk;
		logic [7:0] mode;
		logic [7:0] thr;
		logic thr_full;
		logic tx_busy;
		logic [10:0] tx_shift;
		logic [3:0] tx_left;
		logic [3:0] tx1x_cnt;
		logic tx16_wave;
		logic txd;
	} chan_t;

	typedef struct packed {
		chan_t [1:0] ch;
		logic [7:0] out_sel;
		logic [7:0] latch;
		logic [7:0] rdata;
		logic [7:0] pins;
		logic [7:0] pins_oe_n;
	} state_t;

endpackage

// ---- hw/uart_status_and_output_port.sv ----
// Overview of operation
// R01: Set received-break when an all-zero character of set length lacks its stop bit.
// R02: A break fills one FIFO entry; loads resume after two marking 1X edges.
// R03: Set change-in-break status at break start and again at break end.
// R04: Breaks starting mid-character are caught if the line stays low one more character.
// R05: Sample stop bit mid first stop position; missing stop sets framing error.
// R06: Break, framing, parity flags describe the FIFO head; valid only with receiver ready.
// R07: Parity error set on wrong parity only in with-parity or force-parity mode.
// R08: In multidrop mode the parity flag holds the received address/data bit.
// R09: New character with full FIFO and waiting character sets overrun, discards waiting one.
// R10: Transmitter-empty sets after last stop with holding empty; clears on load or disable.
// R11: Transmitter-ready sets on transfer or first enable; clears on load or disable.
// R12: FIFO-full sets when third entry fills; read clears it unless a character waits.
// R13: Receiver-ready sets on FIFO entry; read clears it only if FIFO becomes empty.
// R14: Channel B has an identical status register for its own receiver and transmitter.
// R15: Pins 7 and 6 give inverted latch or open-collector inverted transmitter-ready.
// R16: Pins 5 and 4 give inverted latch or open-collector inverted receiver interrupt.
// R17: Pin 3 select: inverted latch, counter output, B transmit 1X, B receive 1X.
// R18: Pin 3 as counter output is open-collector and follows the counter/timer output.
// R19: Software keeps pin 3 select at zero until the timer is programmed.
// R20: Pin 2 select: inverted latch, A transmit clock, A transmit 1X, A receive 1X.
// R21: Latch holds inverted pin levels; set and reset writes touch only one-bits.
// R22: Reset-error-status command clears break, parity, framing and overrun together.
// R23: Channel B receiver interrupt bit shows receiver-ready or FIFO-full per mode bit.
// R24: Reset clears all status flags and selects inverted latch on every pin.
//
// The address map and strobed register access are this design's own decisions.
module uart_status_and_output_port (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	input wire logic [uart_status_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [uart_status_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [uart_status_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic [1:0] rxd_i,
	output logic [1:0] txd_o,
	input wire logic [1:0] rx_tick16_i,
	input wire logic [1:0] tx_tick16_i,
	input wire logic tx_a_ext_1x_i,
	input wire logic ctr_out_i,
	input wire logic ctr_ready_i,
	output logic [7:0] output_pins_o,
	output logic [7:0] output_pins_oe_n_o
);
	import uart_status_pkg::*;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	// Character length 5..8 from the two length bits
	function automatic logic [3:0] char_len(input logic [7:0] mode);
		char_len = MIN_CHAR_LEN + {2'b00, mode[MODE_LEN_LSB +: 2]};
	endfunction

	function automatic logic parity_on(input logic [7:0] mode);
		parity_on = (mode[MODE_PMODE_LSB +: 2] != PM_NONE);
	endfunction

	// Head-of-queue error bits are gated by receiver ready
	function automatic logic [7:0] status_byte(input chan_t ch);
		logic rdy;
		rdy = (ch.fifo_cnt != 2'd0);
		status_byte = '0;
		status_byte[ST_BRK] = ch.fifo[0].brk & rdy; // R06
		status_byte[ST_FE] = ch.fifo[0].fe & rdy;
		status_byte[ST_PE] = ch.fifo[0].pe & rdy;
		status_byte[ST_OVR] = ch.overrun;
		status_byte[ST_TX_UNDERRUN_FLAG] = ch.tx_underrun_flag;
		status_byte[ST_TX_HOLDING_EMPTY] = ch.tx_holding_empty;
		status_byte[ST_RX_QUEUE_FULL_FLAG] = ch.rx_queue_full_flag;
		status_byte[ST_RX_CHAR_AVAILABLE] = rdy; // R13
	endfunction

	// Receiver interrupt source chosen by the mode register
	function automatic logic rx_irq(input chan_t ch);
		rx_irq = ch.mode[MODE_RXIRQ_SEL] ? ch.rx_queue_full_flag : (ch.fifo_cnt != 2'd0); // R23
	endfunction

	state_t q;
	state_t n;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		entry_t newc;
		entry_t [2:0] f;
		logic [1:0] fc;
		logic hv;
		logic push;
		logic pop;
		logic rx_act;
		logic [1:0] pm;
		logic [3:0] len;
		logic [7:0] dm;
		logic pbit;
		logic [9:0] tmp;
		logic [3:0] addr_c;
		logic [7:0] cmd;
		logic [7:0] lvl;
		logic [7:0] oc;
		newc = '0;
		f = '0;
		fc = '0;
		hv = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		rx_act = 1'b0;
		pm = '0;
		len = '0;
		dm = '0;
		pbit = 1'b0;
		tmp = '0;
		addr_c = '0;
		cmd = reg_wdata_i;
		lvl = '0;
		oc = '0;
		n = q;
		n.rdata = '0;

		// Both channels share one body; only the address offset differs
		for (int c = 0; c < 2; c++) begin // R14
			addr_c = 4'(c);
			pm = q.ch[c].mode[MODE_PMODE_LSB +: 2];
			len = char_len(q.ch[c].mode);
			push = 1'b0;
			newc = '0;
			// Three-stage line synchroniser; accept a level once stages two and three agree
			n.ch[c].rx_sync = {q.ch[c].rx_sync[1:0], rxd_i[c]};
			if (q.ch[c].rx_sync[2] == q.ch[c].rx_sync[1]) begin
				n.ch[c].rx_line = q.ch[c].rx_sync[2];
			end

			// Channel commands, applied before events so events win
			if (reg_wr_i && reg_addr_i == ADDR_CMD_A + addr_c) begin
				if (cmd[CMD_RX_LSB +: 2] == CMD_EN) begin
					n.ch[c].rx_en = 1'b1;
				end else if (cmd[CMD_RX_LSB +: 2] == CMD_DIS) begin
					n.ch[c].rx_en = 1'b0;
				end
				if (cmd[CMD_TX_LSB +: 2] == CMD_EN) begin
					n.ch[c].tx_en = 1'b1;
					if (!q.ch[c].tx_en) begin
						n.ch[c].tx_holding_empty = 1'b1; // R11
						n.ch[c].thr_full = 1'b0;
					end
				end else if (cmd[CMD_TX_LSB +: 2] == CMD_DIS) begin
					// Character in flight still finishes
					n.ch[c].tx_en = 1'b0;
					n.ch[c].tx_holding_empty = 1'b0; // R11
					n.ch[c].tx_underrun_flag = 1'b0; // R10
					n.ch[c].thr_full = 1'b0;
				end
				case (cmd[CMD_MISC_LSB +: 3])
					MISC_RST_RX: begin
						n.ch[c].rx_en = 1'b0;
						n.ch[c].fifo_cnt = '0;
						n.ch[c].rx_queue_full_flag = 1'b0;
						n.ch[c].hold_valid = 1'b0;
						n.ch[c].rx_state = RX_IDLE;
					end
					MISC_RST_TX: begin
						n.ch[c].tx_en = 1'b0;
						n.ch[c].tx_holding_empty = 1'b0;
						n.ch[c].tx_underrun_flag = 1'b0;
						n.ch[c].thr_full = 1'b0;
						n.ch[c].tx_busy = 1'b0;
						n.ch[c].tx_left = '0;
						n.ch[c].txd = 1'b1;
					end
					MISC_RST_ERR: begin
						n.ch[c].overrun = 1'b0; // R22
						for (int e = 0; e < 3; e++) begin
							n.ch[c].fifo[e].brk = 1'b0;
							n.ch[c].fifo[e].fe = 1'b0;
							n.ch[c].fifo[e].pe = 1'b0;
						end
						n.ch[c].hold.brk = 1'b0;
						n.ch[c].hold.fe = 1'b0;
						n.ch[c].hold.pe = 1'b0;
					end
					MISC_RST_BRK: n.ch[c].chg_brk = 1'b0;
					default: ;
				endcase
			end
			if (reg_wr_i && reg_addr_i == ADDR_MODE_A + addr_c) begin
				n.ch[c].mode = reg_wdata_i;
			end
			rx_act = n.ch[c].rx_en | (pm == PM_MULTI);

			// Receiver, advanced on the 16X tick
			if (rx_tick16_i[c]) begin
				n.ch[c].rx_cnt = q.ch[c].rx_cnt + 4'd1;
				// End of break: two successive 1X edges with the line marking
				if (q.ch[c].brk_active) begin
					if (!q.ch[c].rx_line) begin
						n.ch[c].mark_cnt = '0;
					end else if (q.ch[c].rx_cnt == SAMPLE_MID) begin
						if (q.ch[c].mark_cnt == MARK_EDGES - 2'd1) begin
							n.ch[c].brk_active = 1'b0; // R02
							n.ch[c].mark_cnt = '0;
							n.ch[c].chg_brk = 1'b1; // R03
						end else begin
							n.ch[c].mark_cnt = q.ch[c].mark_cnt + 2'd1;
						end
					end
				end
				case (q.ch[c].rx_state)
					RX_IDLE: begin
						// No new character while a break is still on the line
						if (rx_act && !q.ch[c].brk_active && !q.ch[c].rx_line) begin // R02
							n.ch[c].rx_state = RX_START;
							n.ch[c].rx_cnt = '0;
						end
					end
					RX_START: begin
						if (q.ch[c].rx_cnt == SAMPLE_START) begin
							n.ch[c].rx_cnt = '0;
							n.ch[c].rx_bit = '0;
							n.ch[c].rx_shift = '0;
							n.ch[c].rx_state = q.ch[c].rx_line ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						if (q.ch[c].rx_cnt == SAMPLE_MID) begin
							n.ch[c].rx_shift = {q.ch[c].rx_line, q.ch[c].rx_shift[7:1]};
							n.ch[c].rx_bit = q.ch[c].rx_bit + 3'd1;
							if ({1'b0, q.ch[c].rx_bit} == len - 4'd1) begin
								n.ch[c].rx_state = parity_on(q.ch[c].mode) ? RX_PAR : RX_STOP;
							end
						end
					end
					RX_PAR: begin
						if (q.ch[c].rx_cnt == SAMPLE_MID) begin
							n.ch[c].rx_pbit = q.ch[c].rx_line;
							n.ch[c].rx_state = RX_STOP;
						end
					end
					RX_STOP: begin
						if (q.ch[c].rx_cnt == SAMPLE_MID) begin
							push = 1'b1;
							n.ch[c].rx_state = RX_IDLE;
							newc.data = q.ch[c].rx_shift >> (4'd8 - len);
							newc.fe = !q.ch[c].rx_line; // R05
							// Also catches a break that began mid-character one frame later
							newc.brk = newc.fe && (q.ch[c].rx_shift == 8'h00) &&
								!(parity_on(q.ch[c].mode) && q.ch[c].rx_pbit); // R01 R04
							case (pm)
								PM_WITH: newc.pe = (^{newc.data, q.ch[c].rx_pbit}) !=
									q.ch[c].mode[MODE_PAR_TYPE]; // R07
								PM_FORCE: newc.pe = q.ch[c].rx_pbit != q.ch[c].mode[MODE_PAR_TYPE];
								PM_MULTI: newc.pe = q.ch[c].rx_pbit; // R08
								default: newc.pe = 1'b0;
							endcase
							if (newc.brk) begin
								newc.pe = 1'b0;
								n.ch[c].brk_active = 1'b1; // R02
								n.ch[c].mark_cnt = '0;
								n.ch[c].chg_brk = 1'b1; // R03
							end
						end
					end
					default: n.ch[c].rx_state = RX_IDLE;
				endcase
			end
			if (!rx_act && q.ch[c].rx_state != RX_IDLE) begin
				n.ch[c].rx_state = RX_IDLE;
			end

			// Receive queue: pop on buffer read, then load the new character
			f = n.ch[c].fifo;
			fc = n.ch[c].fifo_cnt;
			hv = n.ch[c].hold_valid;
			pop = reg_rd_i && reg_addr_i == ADDR_RXDATA_A + addr_c && q.ch[c].fifo_cnt != 2'd0;
			if (pop) begin
				f[0] = f[1];
				f[1] = f[2];
				fc = fc - 2'd1;
				if (hv) begin
					// Waiting character moves in; queue stays full
					f[2] = n.ch[c].hold;
					fc = FIFO_DEPTH;
					hv = 1'b0;
				end else begin
					n.ch[c].rx_queue_full_flag = 1'b0; // R12
				end
			end
			if (push) begin
				if (fc < FIFO_DEPTH) begin
					f[fc] = newc;
					fc = fc + 2'd1;
					if (fc == FIFO_DEPTH) begin
						n.ch[c].rx_queue_full_flag = 1'b1; // R12
					end
				end else begin
					// A second waiter overwrites the first, losing it and its status
					if (hv) begin
						n.ch[c].overrun = 1'b1; // R09
					end
					n.ch[c].hold = newc;
					hv = 1'b1;
				end
			end
			n.ch[c].fifo = f;
			n.ch[c].fifo_cnt = fc;
			n.ch[c].hold_valid = hv;

			// Transmitter, bit boundaries on the free-running 1X phase
			if (tx_tick16_i[c]) begin
				n.ch[c].tx1x_cnt = q.ch[c].tx1x_cnt + 4'd1;
				n.ch[c].tx16_wave = !q.ch[c].tx16_wave;
				if (q.ch[c].tx1x_cnt == SAMPLE_MID) begin
					if (q.ch[c].tx_left != 4'd0) begin
						n.ch[c].txd = q.ch[c].tx_shift[0];
						n.ch[c].tx_shift = {1'b1, q.ch[c].tx_shift[10:1]};
						n.ch[c].tx_left = q.ch[c].tx_left - 4'd1;
					end else begin
						n.ch[c].tx_busy = 1'b0;
						if (q.ch[c].thr_full && q.ch[c].tx_en) begin
							dm = q.ch[c].thr;
							tmp = 10'h3FF;
							for (int i = 0; i < 8; i++) begin
								if (4'(i) < len) begin
									tmp[i] = dm[i];
								end else begin
									dm[i] = 1'b0;
								end
							end
							pbit = (pm == PM_WITH) ? (^dm ^ q.ch[c].mode[MODE_PAR_TYPE]) :
								q.ch[c].mode[MODE_PAR_TYPE];
							if (parity_on(q.ch[c].mode)) begin
								tmp[len] = pbit;
							end
							n.ch[c].tx_shift = {tmp, 1'b0};
							n.ch[c].tx_left = len + 4'd2 + {3'b000, parity_on(q.ch[c].mode)};
							n.ch[c].tx_busy = 1'b1;
							n.ch[c].thr_full = 1'b0;
							n.ch[c].tx_holding_empty = 1'b1; // R11
						end else if (q.ch[c].tx_busy && q.ch[c].tx_en) begin
							n.ch[c].tx_underrun_flag = 1'b1; // R10
						end
					end
				end
			end
			// CPU load; ignored while disabled so it is never sent
			if (reg_wr_i && reg_addr_i == ADDR_TXHOLD_A + addr_c && n.ch[c].tx_en) begin
				n.ch[c].thr = reg_wdata_i;
				n.ch[c].thr_full = 1'b1;
				n.ch[c].tx_holding_empty = 1'b0; // R11
				n.ch[c].tx_underrun_flag = 1'b0; // R10
			end
		end

		// Output configuration and latch writes
		if (reg_wr_i && reg_addr_i == ADDR_OUT_SEL) begin
			n.out_sel = reg_wdata_i;
		end
		if (reg_wr_i && reg_addr_i == ADDR_LATCH_SET) begin
			n.latch = q.latch | reg_wdata_i; // R21
		end
		if (reg_wr_i && reg_addr_i == ADDR_LATCH_CLR) begin
			n.latch = q.latch & ~reg_wdata_i; // R21
		end

		// Read data, valid only in the cycle after the strobe
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_STATUS_A: n.rdata = status_byte(q.ch[0]);
				ADDR_STATUS_A + 4'd1: n.rdata = status_byte(q.ch[1]); // R14
				ADDR_RXDATA_A: n.rdata = q.ch[0].fifo_cnt != 2'd0 ? q.ch[0].fifo[0].data : 8'h00;
				ADDR_RXDATA_A + 4'd1: n.rdata = q.ch[1].fifo_cnt != 2'd0 ? q.ch[1].fifo[0].data : 8'h00;
				ADDR_MODE_A: n.rdata = q.ch[0].mode;
				ADDR_MODE_A + 4'd1: n.rdata = q.ch[1].mode;
				ADDR_OUT_SEL: n.rdata = q.out_sel;
				ADDR_LATCH_SET: n.rdata = q.latch;
				ADDR_IRQ_STATUS: begin
					n.rdata[IRQ_BRK_B] = q.ch[1].chg_brk;
					n.rdata[IRQ_RX_B] = rx_irq(q.ch[1]);
					n.rdata[IRQ_TX_B] = q.ch[1].tx_holding_empty;
					n.rdata[IRQ_CTR] = ctr_ready_i;
					n.rdata[IRQ_BRK_A] = q.ch[0].chg_brk;
					n.rdata[IRQ_RX_A] = rx_irq(q.ch[0]);
					n.rdata[IRQ_TX_A] = q.ch[0].tx_holding_empty;
				end
				default: n.rdata = 8'h00;
			endcase
		end

		// Output pins: inverted latch unless an auxiliary function is selected
		lvl = ~q.latch; // R21
		if (q.out_sel[7]) begin
			lvl[7] = !q.ch[1].tx_holding_empty; // R15
			oc[7] = 1'b1;
		end
		if (q.out_sel[6]) begin
			lvl[6] = !q.ch[0].tx_holding_empty; // R15
			oc[6] = 1'b1;
		end
		// Unmasked: the interrupt mask never gates these pins
		if (q.out_sel[5]) begin
			lvl[5] = !rx_irq(q.ch[1]); // R16
			oc[5] = 1'b1;
		end
		if (q.out_sel[4]) begin
			lvl[4] = !rx_irq(q.ch[0]); // R16
			oc[4] = 1'b1;
		end
		case (q.out_sel[SEL_OP3_LSB +: 2])
			SEL_FUNC: begin
				lvl[3] = ctr_out_i; // R18
				oc[3] = 1'b1;
			end
			SEL_TX1X: lvl[3] = q.ch[1].tx1x_cnt[3]; // R17
			SEL_RX1X: lvl[3] = q.ch[1].rx_cnt[3]; // R17
			default: ;
		endcase
		case (q.out_sel[SEL_OP2_LSB +: 2])
			SEL_FUNC: lvl[2] = tx_a_ext_1x_i ? q.ch[0].tx1x_cnt[3] : q.ch[0].tx16_wave; // R20
			SEL_TX1X: lvl[2] = q.ch[0].tx1x_cnt[3]; // R20
			SEL_RX1X: lvl[2] = q.ch[0].rx_cnt[3]; // R20
			default: ;
		endcase
		// Open-collector pins only ever pull low; release means high
		n.pins = lvl & ~oc;
		n.pins_oe_n = lvl & oc;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '0; // R24
			for (int c = 0; c < 2; c++) begin
				q.ch[c].rx_sync <= 3'b111;
				q.ch[c].rx_line <= 1'b1;
				q.ch[c].mode <= MODE_RESET;
				q.ch[c].txd <= 1'b1;
			end
			q.out_sel <= OUT_SEL_RESET; // R24
			q.latch <= LATCH_RESET;
			q.pins <= ~LATCH_RESET;
		end else if (clk_en_i) begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata_o = q.rdata;
	assign txd_o = {q.ch[1].txd, q.ch[0].txd};
	assign output_pins_o = q.pins;
	assign output_pins_oe_n_o = q.pins_oe_n;

endmodule

// ---- verif/uart_status_and_output_port_chk.sv ----
module uart_status_and_output_port_chk
	import uart_status_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	input wire logic ctr_out_i,
	input wire logic [7:0] output_pins_o,
	input wire logic [7:0] output_pins_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sel_q;
	logic [7:0] lm;
	logic wset;
	logic wclr;
	logic rst_a;
	// Shadow of pin select, so latch-driven pins are known
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_q <= 8'h00;
		end else if (reg_wr_i && clk_en_i && reg_addr_i == ADDR_OUT_SEL) begin
			sel_q <= reg_wdata_i;
		end
	end
	// Pins showing the latch and the bus strobes of interest
	assign lm = {~sel_q[7:4], sel_q[3:2] == 2'b00, sel_q[1:0] == 2'b00, 2'b11};
	assign wset = reg_wr_i && clk_en_i && reg_addr_i == ADDR_LATCH_SET;
	assign wclr = reg_wr_i && clk_en_i && reg_addr_i == ADDR_LATCH_CLR;
	assign rst_a = reg_rd_i && clk_en_i && reg_addr_i == ADDR_STATUS_A;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	property p_latch_set;
		wset |-> ##2 ((output_pins_o & $past(reg_wdata_i, 2) & lm) == 8'h00);
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("latch set pin not low");
	property p_latch_clr;
		wclr |-> ##2 ((output_pins_o & $past(reg_wdata_i, 2) & lm) == ($past(reg_wdata_i, 2) & lm));
	endproperty
	a_latch_clr: assert property (p_latch_clr) else $error("latch clear pin not high");
	property p_latch_oe;
		(wset || wclr) |-> ##2 ((output_pins_oe_n_o & lm) == 8'h00);
	endproperty
	a_latch_oe: assert property (p_latch_oe) else $error("latch pin not driven");
	property p_rst_pins;
		$rose(resetn_i) |-> output_pins_o == 8'hFF && output_pins_oe_n_o == 8'h00;
	endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pins wrong after reset");
	property p_pin3;
		($past(sel_q[3:2]) == SEL_FUNC) |-> output_pins_oe_n_o[3] == $past(ctr_out_i) && !output_pins_o[3];
	endproperty
	a_pin3: assert property (p_pin3) else $error("pin 3 not counter output");
	property p_status_hi;
		rst_a ##1 !reg_rdata_o[ST_RX_CHAR_AVAILABLE] |-> reg_rdata_o[7:5] == 3'b000;
	endproperty
	a_status_hi: assert property (p_status_hi) else $error("error flags without data");
	property p_rx_queue_full_flag;
		rst_a ##1 reg_rdata_o[ST_RX_QUEUE_FULL_FLAG] |-> reg_rdata_o[ST_RX_CHAR_AVAILABLE];
	endproperty
	a_rx_queue_full_flag: assert property (p_rx_queue_full_flag) else $error("queue full without ready");
	property p_reset_err;
		(reg_wr_i && reg_addr_i == ADDR_CMD_A && reg_wdata_i[6:4] == MISC_RST_ERR) ##2 rst_a
			|=> reg_rdata_o[7:4] == 4'h0;
	endproperty
	a_reset_err: assert property (p_reset_err) else $error("error flags not cleared");
endmodule

bind uart_status_and_output_port uart_status_and_output_port_chk chk (.clk_i(clk_i),
	.resetn_i(resetn_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .ctr_out_i(ctr_out_i), .output_pins_o(output_pins_o),
	.output_pins_oe_n_o(output_pins_oe_n_o));

// ---- verif/serial_line_model.sv ----
module serial_line_model (
	input wire logic clk_i,
	output logic [1:0] tick_o,
	output logic [1:0] rxd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tick_q = 1'b0;
	logic line_q = 1'b1;
	// 16X tick every other clock; channel B line stays marking
	always @(posedge clk_i) begin
		tick_q <= ~tick_q;
	end
	assign tick_o = {2{tick_q}};
	assign rxd_o = {1'b1, line_q};
	// One bit time is 16 ticks, so 32 clocks
	task automatic bit_out(input logic b, input int n);
		line_q <= b;
		repeat (32 * n) @(posedge clk_i);
	endtask
	// Start, eight data bits LSB first, stop held as asked, then marking
	task automatic send(input logic [7:0] d, input logic stop, input int hold);
		bit_out(1'b0, 1);
		for (int i = 0; i < 8; i++) begin
			bit_out(d[i], 1);
		end
		bit_out(stop, 1 + hold);
		bit_out(1'b1, 2);
	endtask
endmodule

// ---- verif/tb_uart_status_and_output_port.sv ----
module tb_uart_status_and_output_port;
	import uart_status_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic ctr_out_i = 1'b0;
	logic [7:0] rdata, pins, oe_n, v;
	logic [1:0] txd, tick, rxd;
	int fail_count = 0;
	int n_checks = 0;
	// Clock and a counter output that toggles every cycle
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		ctr_out_i <= ~ctr_out_i;
	end
	uart_status_and_output_port dut (.clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .rxd_i(rxd), .txd_o(txd),
		.rx_tick16_i(tick), .tx_tick16_i(tick), .tx_a_ext_1x_i(1'b0), .ctr_out_i(ctr_out_i),
		.ctr_ready_i(1'b0), .output_pins_o(pins), .output_pins_oe_n_o(oe_n));
	serial_line_model line (.clk_i(clk_i), .tick_o(tick), .rxd_o(rxd));
	// ----------------------------------------------------------------
	// Bus cycles and comparison
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m, input string n);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(n, e, rdata & m);
	endtask
	task automatic end_of_test();
		if (fail_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		rc(ADDR_STATUS_A, 8'h00, 8'hFF, "status_a");
		rc(4'h1, 8'h00, 8'hFF, "status_b");
		chk("pins", 8'hFF, pins);
		wr(ADDR_LATCH_SET, 8'hA5);
		wr(ADDR_LATCH_CLR, 8'h05);
		rc(ADDR_LATCH_SET, 8'hA0, 8'hFF, "latch");
		chk("pins", 8'h5F, pins);
		wr(ADDR_OUT_SEL, 8'h54);
		wr(ADDR_CMD_A, 8'h05);
		rc(ADDR_STATUS_A, 8'h04, 8'hFF, "tx ready");
		chk("pin6 pulled low", 8'h00, {7'h00, oe_n[6] | pins[6]});
		wr(ADDR_TXHOLD_A, 8'h55);
		// Count low cycles of the frame on the settled line; 0x55 has four zero bits, five low bits with the start bit
		v = 8'h00;
		repeat (500) begin
			@(negedge clk_i);
			if (txd[0] === 1'b0) begin
				v = v + 8'h01;
			end
		end
		chk("txd low cycles", 8'hA0, v);
		rc(ADDR_STATUS_A, 8'h0C, 8'hFF, "tx empty");
		wr(ADDR_CMD_A, 8'h08);
		rc(ADDR_STATUS_A, 8'h00, 8'hFF, "tx disabled");
		wr(ADDR_CMD_A, 8'h04);
		// Three characters fill the queue, then drain it
		for (int i = 0; i < 3; i++) begin
			line.send(8'h31, 1'b1, 0);
		end
		rc(ADDR_STATUS_A, 8'h07, 8'hFF, "queue full");
		chk("pin4 pulled low", 8'h00, {7'h00, oe_n[4] | pins[4]});
		rc(ADDR_RXDATA_A, 8'h31, 8'hFF, "rx data");
		rc(ADDR_STATUS_A, 8'h05, 8'hFF, "after pop");
		for (int i = 0; i < 2; i++) begin
			rc(ADDR_RXDATA_A, 8'h31, 8'hFF, "rx data");
		end
		rc(ADDR_STATUS_A, 8'h04, 8'hFF, "queue empty");
		chk("pin4 released", 8'h01, {7'h00, oe_n[4]});
		line.send(8'h0F, 1'b0, 0);
		rc(ADDR_STATUS_A, 8'h45, 8'hFF, "framing");
		wr(ADDR_CMD_A, 8'h40);
		rc(ADDR_STATUS_A, 8'h05, 8'hFF, "error reset");
		rc(ADDR_RXDATA_A, 8'h0F, 8'hFF, "rx data");
		// Break held low for two extra bit times
		line.send(8'h00, 1'b0, 2);
		rc(ADDR_STATUS_A, 8'h81, 8'h81, "break");
		rc(ADDR_IRQ_STATUS, 8'h07, 8'h07, "irq status");
		rc(ADDR_RXDATA_A, 8'h00, 8'hFF, "break data");
		rc(ADDR_STATUS_A, 8'h04, 8'hFF, "one entry");
		// Seven bits, even parity: the eighth bit sent lands as a wrong parity bit
		wr(ADDR_MODE_A, 8'h02);
		line.send(8'h01, 1'b1, 0);
		rc(ADDR_STATUS_A, 8'h25, 8'hFF, "parity");
		rc(ADDR_RXDATA_A, 8'h01, 8'hFF, "parity data");
		end_of_test();
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		end_of_test();
	end
endmodule
